//--- pkg/ccoc_pkg.sv
// clock control package: register indices, field layouts, reset values
// assumes register bytes are word aligned on a 32-bit AXI4-Lite bus
package ccoc_pkg;

  // ****************************************************
  // register map (index, byte address is four times it)
  // ****************************************************
  localparam int ADDR_W = 12;
  localparam logic [7:0] IDX_TUNE = 8'h96;
  localparam logic [7:0] IDX_WDCTL = 8'hA7;
  localparam logic [7:0] IDX_CLKCFG = 8'h10;
  localparam logic [7:0] IDX_AUX = 8'h11;
  localparam logic [7:0] IDX_USER_CONFIG_TWO = 8'h12;
  localparam logic [7:0] IDX_IRQSTAT = 8'h13;
  localparam logic [7:0] IDX_IRQEN = 8'h14;
  localparam logic [7:0] IDX_IRQCLR = 8'h15;

  // ****************************************************
  // field positions
  // ****************************************************
  localparam int CFG_SRC_LSB = 0;
  localparam int CFG_WDRATE_BIT = 2;
  localparam int CFG_DONE_BIT = 7;
  localparam int AUX_LP_BIT = 7;
  localparam int USER_CONFIG_TWO_DBL_BIT = 7;
  localparam int IRQ_W = 2;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_REFUSED_BIT = 1;

  // ****************************************************
  // encodings and layouts
  // ****************************************************
  typedef enum logic [1:0] {
    SRC_WDOSC = 2'h0,
    SRC_RC = 2'h1,
    SRC_XTAL = 2'h2,
    SRC_EXT = 2'h3
  } ccoc_src_e;

  typedef struct packed {
    logic rcSysSel;
    logic clkOutEn;
    logic [5:0] tune;
  } ccoc_tune_s;

  typedef struct packed {
    logic [2:0] prescale;
    logic [1:0] unused;
    logic run;
    logic timeoutFlag;
    logic clkSel;
  } ccoc_wdctl_s;

  typedef struct packed {
    logic [1:0] src;
    logic wdRateLow;
  } ccoc_cfg_s;

  // ****************************************************
  // reset values
  // ****************************************************
  localparam logic [2:0] WD_PRESCALE_RST = 3'h7;
  localparam logic [1:0] WD_UNUSED_RST = 2'h0;
  localparam logic WD_RUN_RST = 1'b1;
  localparam logic WD_CLKSEL_RST = 1'b1;
  localparam ccoc_src_e SRC_RST = SRC_RC;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : ccoc_pkg

//--- rtl/ccoc_top.sv
// clock source selection, switching, clock output and trim/watchdog regs
// assumes oscillator levels and ready flags arrive asynchronously, reset
// cause pulses and crystal usage flags come from logic on sys_clk
//
// Function
// - clock output only when no source, RTC or watchdog uses the crystal
// - clock output pin driven only while its enable bit is set
// - clock output runs at half the CPU clock rate
// - six-bit tune field sets the RC oscillator frequency
// - trim loaded with factory value only on power-on and watchdog reset
// - software may rewrite the tune value at any time
// - doubler bit doubles the RC oscillator output
// - low-power access bit clears on reset; set only at slow CPU clock (not enforced: an AUX write with bit 7 set sets it at any clock)
// - watchdog oscillator selectable between two rates as system clock
// - external mode takes CPU clock from input pin, sampled on sys_clk, at below half the sys_clk rate
// - external mode lets crystal-out pin be port pin or clock output
// - system clock source switchable among four sources while running
// - switch done flag clears at switch start, sets on completion
// - clock configuration writes refused while switch done flag is zero
// - watchdog control resets to prescale ones, run one, clock select one
// - timeout flag set by watchdog reset, cleared by power-on reset
`timescale 1ns/100ps
module ccoc_top
  import ccoc_pkg::*;
#(
  parameter logic [5:0] TUNE_FACTORY = 6'h20 // factory trim value
) (
  input wire logic sys_clk, // 200 MHz system clock
  input wire logic rst_b, // asynchronous reset, active low
  input wire logic porEvt, // power-on reset cause pulse
  input wire logic wdtRstEvt, // watchdog reset cause pulse
  input wire logic [3:0] oscLvlIn, // source levels, indexed by source
  input wire logic [3:0] oscRdyIn, // source ready flags, by source
  input wire logic rtcUsesXtal, // RTC clocked from crystal
  input wire logic wdtUsesXtal, // watchdog clocked from crystal
  input wire logic [ccoc_pkg::ADDR_W-1:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // write strobes
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [ccoc_pkg::ADDR_W-1:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  output logic cpuClockTick, // one-cycle pulse per CPU clock
  output ccoc_pkg::ccoc_src_e activeSrc, // source now driving the CPU clock
  output logic wdOscRateLow, // watchdog oscillator at low rate
  output logic rcDoublerOn, // RC doubler enabled
  output logic [5:0] rcTune, // RC oscillator tune value
  output logic rcSysSel, // RC system clock select bit
  output logic lowPowerAccess, // low-power clock access
  output ccoc_pkg::ccoc_wdctl_s wdCtl, // watchdog control to watchdog
  output logic crystalOutPinO, // clock output level
  output logic crystalOutPinOe, // clock output drive enable
  output logic irqOut // interrupt, high level
);
  import ccoc_pkg::*;

  // ****************************************************
  // pin synchronisers and edge detection
  // ****************************************************
  logic [7:0] syncA_ff;
  logic [7:0] syncB_ff;
  logic [3:0] lvlPrev_ff;
  logic [3:0] srcLvl;
  logic [3:0] srcRdy;
  logic [3:0] riseTick;
  logic [3:0] fallTick;
  logic [3:0] srcTick;

  // two flops per asynchronous source level and ready flag
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      syncA_ff <= 8'h00;
      syncB_ff <= 8'h00;
      lvlPrev_ff <= 4'h0;
    end else begin
      syncA_ff <= {oscRdyIn, oscLvlIn};
      syncB_ff <= syncA_ff;
      lvlPrev_ff <= syncB_ff[3:0];
    end
  end

  // each source becomes a tick stream; the doubled RC ticks on both edges
  assign srcLvl = syncB_ff[3:0];
  assign srcRdy = syncB_ff[7:4];
  assign riseTick = srcLvl & ~lvlPrev_ff;
  assign fallTick = ~srcLvl & lvlPrev_ff;
  assign srcTick[SRC_WDOSC] = riseTick[SRC_WDOSC];
  assign srcTick[SRC_RC] = riseTick[SRC_RC] |
                           (rcDoublerOn & fallTick[SRC_RC]);
  assign srcTick[SRC_XTAL] = riseTick[SRC_XTAL];
  assign srcTick[SRC_EXT] = riseTick[SRC_EXT];

  // ****************************************************
  // AXI4-Lite slave
  // ****************************************************
  logic awHeld_ff;
  logic wHeld_ff;
  logic [ADDR_W-1:0] awAddr_ff;
  logic [31:0] wData_ff;
  logic wLane0_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [1:0] rresp_ff;
  logic [31:0] rdata_ff;
  logic wrEn;
  logic [7:0] wrIdx;
  logic wrInRange;
  logic wrHit;
  logic [7:0] rdIdx;
  logic rdInRange;
  logic rdHit;
  logic [7:0] rdByte;
  logic arTake;

  // address and data are taken independently, answer once both are held
  assign awready = !awHeld_ff && !bvalid_ff;
  assign wready = !wHeld_ff && !bvalid_ff;
  assign wrEn = awHeld_ff && wHeld_ff && !bvalid_ff;
  assign wrIdx = awAddr_ff[9:2];
  assign wrInRange = (awAddr_ff[ADDR_W-1:10] == '0);
  assign wrHit = wrInRange && (wrIdx == IDX_TUNE || wrIdx == IDX_WDCTL ||
                 wrIdx == IDX_CLKCFG || wrIdx == IDX_AUX ||
                 wrIdx == IDX_USER_CONFIG_TWO || wrIdx == IDX_IRQSTAT ||
                 wrIdx == IDX_IRQEN || wrIdx == IDX_IRQCLR);
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;

  // write channel holding registers and response
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      awHeld_ff <= 1'b0;
      wHeld_ff <= 1'b0;
      awAddr_ff <= '0;
      wData_ff <= 32'h0000_0000;
      wLane0_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awHeld_ff <= 1'b1;
        awAddr_ff <= awaddr;
      end
      if (wvalid && wready) begin
        wHeld_ff <= 1'b1;
        wData_ff <= wdata;
        wLane0_ff <= wstrb[0];
      end
      if (wrEn) begin
        awHeld_ff <= 1'b0;
        wHeld_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= wrHit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_ff && bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // register write strobes, byte lane 0 carries the register
  logic wrByte;
  logic wrTune;
  logic wrWdctl;
  logic wrCfg;
  logic wrAux;
  logic wrUcfg2;
  logic wrIrqEn;
  logic wrIrqClr;
  assign wrByte = wrEn && wrInRange && wLane0_ff;
  assign wrTune = wrByte && (wrIdx == IDX_TUNE);
  assign wrWdctl = wrByte && (wrIdx == IDX_WDCTL);
  assign wrCfg = wrByte && (wrIdx == IDX_CLKCFG);
  assign wrAux = wrByte && (wrIdx == IDX_AUX);
  assign wrUcfg2 = wrByte && (wrIdx == IDX_USER_CONFIG_TWO);
  assign wrIrqEn = wrByte && (wrIdx == IDX_IRQEN);
  assign wrIrqClr = wrByte && (wrIdx == IDX_IRQCLR);

  // ****************************************************
  // source switching
  // ****************************************************
  typedef enum logic {ST_IDLE, ST_WAIT} ccoc_sw_e;
  ccoc_sw_e swState_ff;
  ccoc_src_e activeSrc_ff;
  ccoc_src_e pendSrc_ff;
  logic switchDone_ff;
  logic wdRateLow_ff;
  logic cfgAccept;
  logic cfgRefused;
  logic swStart;
  logic swCommit;
  ccoc_src_e reqSrc;

  // clock configuration writes are refused while a switch is in progress
  assign cfgAccept = wrCfg && switchDone_ff;
  assign cfgRefused = wrCfg && !switchDone_ff;
  assign reqSrc = ccoc_src_e'(wData_ff[CFG_SRC_LSB +: 2]);
  assign swStart = cfgAccept && (reqSrc != activeSrc_ff);
  assign swCommit = (swState_ff == ST_WAIT) && srcRdy[pendSrc_ff];

  // old source keeps ticking until the new one reports ready
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      swState_ff <= ST_IDLE;
      activeSrc_ff <= SRC_RST;
      pendSrc_ff <= SRC_RST;
      switchDone_ff <= 1'b1;
      wdRateLow_ff <= 1'b0;
    end else begin
      case (swState_ff)
        ST_IDLE: begin
          if (cfgAccept) begin
            wdRateLow_ff <= wData_ff[CFG_WDRATE_BIT];
          end
          if (swStart) begin
            pendSrc_ff <= reqSrc;
            switchDone_ff <= 1'b0;
            swState_ff <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (swCommit) begin
            activeSrc_ff <= pendSrc_ff;
            switchDone_ff <= 1'b1;
            swState_ff <= ST_IDLE;
          end
        end
        default: swState_ff <= ST_IDLE;
      endcase
    end
  end

  // whole ticks only, so the change-over never cuts a pulse short
  assign cpuClockTick = srcTick[activeSrc_ff];
  assign activeSrc = activeSrc_ff;
  assign wdOscRateLow = wdRateLow_ff;

  // ****************************************************
  // trim and watchdog control (power-on / watchdog reset only)
  // ****************************************************
  ccoc_tune_s tune_ff;
  ccoc_wdctl_s wdctl_ff;

  // loaded with reset values only by the two reset causes, never by rst_b
  always_ff @(posedge sys_clk) begin
    if (porEvt || wdtRstEvt) begin
      tune_ff <= '{rcSysSel: 1'b0, clkOutEn: 1'b0,
                   tune: TUNE_FACTORY};
      wdctl_ff.prescale <= WD_PRESCALE_RST;
      wdctl_ff.unused <= WD_UNUSED_RST;
      wdctl_ff.run <= WD_RUN_RST;
      wdctl_ff.clkSel <= WD_CLKSEL_RST;
      wdctl_ff.timeoutFlag <= !porEvt;
    end else begin
      if (wrTune) begin
        tune_ff <= ccoc_tune_s'(wData_ff[7:0]);
      end
      if (wrWdctl) begin
        wdctl_ff.prescale <= wData_ff[7:5];
        wdctl_ff.run <= wData_ff[2];
        wdctl_ff.clkSel <= wData_ff[0];
        if (!wData_ff[1]) begin
          wdctl_ff.timeoutFlag <= 1'b0;
        end
      end
    end
  end

  assign rcTune = tune_ff.tune;
  assign rcSysSel = tune_ff.rcSysSel;
  assign wdCtl = wdctl_ff;

  // ****************************************************
  // auxiliary, user configuration and interrupts
  // ****************************************************
  logic lowPower_ff;
  logic doubler_ff;
  logic [IRQ_W-1:0] irqStat_ff;
  logic [IRQ_W-1:0] irqEn_ff;
  logic [IRQ_W-1:0] irqSet;
  logic [IRQ_W-1:0] irqClr;

  assign irqSet = {cfgRefused, swCommit};
  assign irqClr = wrIrqClr ? wData_ff[IRQ_W-1:0] : '0;

  // sticky flags: a set in the clearing cycle wins
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      lowPower_ff <= 1'b0;
      doubler_ff <= 1'b0;
      irqStat_ff <= '0;
      irqEn_ff <= '0;
    end else begin
      if (wrAux) begin
        lowPower_ff <= wData_ff[AUX_LP_BIT];
      end
      if (wrUcfg2) begin
        doubler_ff <= wData_ff[USER_CONFIG_TWO_DBL_BIT];
      end
      if (wrIrqEn) begin
        irqEn_ff <= wData_ff[IRQ_W-1:0];
      end
      irqStat_ff <= (irqStat_ff & ~irqClr) | irqSet;
    end
  end

  assign lowPowerAccess = lowPower_ff;
  assign rcDoublerOn = doubler_ff;
  assign irqOut = |(irqStat_ff & irqEn_ff);

  // ****************************************************
  // clock output on the crystal-out pin
  // ****************************************************
  logic clkOutAllowed;
  logic clkOutOn;
  logic clkOutLvl_ff;

  // pin is free only when nothing runs from the crystal
  assign clkOutAllowed = (activeSrc_ff != SRC_XTAL) && !rtcUsesXtal &&
                         !wdtUsesXtal;
  assign clkOutOn = tune_ff.clkOutEn && clkOutAllowed;

  // toggle per CPU tick gives half the CPU clock rate
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      clkOutLvl_ff <= 1'b0;
    end else if (!clkOutOn) begin
      clkOutLvl_ff <= 1'b0;
    end else if (cpuClockTick) begin
      clkOutLvl_ff <= !clkOutLvl_ff;
    end
  end

  assign crystalOutPinO = clkOutLvl_ff;
  assign crystalOutPinOe = clkOutOn;

  // ****************************************************
  // read path
  // ****************************************************
  assign rdIdx = araddr[9:2];
  assign rdInRange = (araddr[ADDR_W-1:10] == '0);
  assign arTake = arvalid && arready;
  assign arready = !rvalid_ff;

  // read decode of every mapped register
  assign rdHit = rdInRange && (rdIdx == IDX_TUNE || rdIdx == IDX_WDCTL ||
                 rdIdx == IDX_CLKCFG || rdIdx == IDX_AUX ||
                 rdIdx == IDX_USER_CONFIG_TWO || rdIdx == IDX_IRQSTAT ||
                 rdIdx == IDX_IRQEN || rdIdx == IDX_IRQCLR);
  assign rdByte =
    (!rdInRange) ? 8'h00 :
    (rdIdx == IDX_TUNE) ? tune_ff :
    (rdIdx == IDX_WDCTL) ? wdctl_ff :
    (rdIdx == IDX_CLKCFG) ? {switchDone_ff, 4'h0, wdRateLow_ff,
                             activeSrc_ff} :
    (rdIdx == IDX_AUX) ? {lowPower_ff, 7'h00} :
    (rdIdx == IDX_USER_CONFIG_TWO) ? {doubler_ff, 7'h00} :
    (rdIdx == IDX_IRQSTAT) ? {6'h00, irqStat_ff} :
    (rdIdx == IDX_IRQEN) ? {6'h00, irqEn_ff} : 8'h00;

  // read answer held until taken
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rvalid_ff <= 1'b0;
      rresp_ff <= RESP_OKAY;
      rdata_ff <= 32'h0000_0000;
    end else if (arTake) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= rdHit ? RESP_OKAY : RESP_SLVERR;
      rdata_ff <= {24'h00_0000, rdByte};
    end else if (rvalid_ff && rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign rvalid = rvalid_ff;
  assign rresp = rresp_ff;
  assign rdata = rdata_ff;

  // ****************************************************
  // assertions
  // ****************************************************
  sequence s_swBegin;
    swStart;
  endsequence
  sequence s_swEnd;
    swCommit;
  endsequence

  property p_clock_output_pin_half;
    @(posedge sys_clk) disable iff (!rst_b)
      (cpuClockTick && clkOutOn) |=> (clkOutLvl_ff != $past(clkOutLvl_ff));
  endproperty
  a_clock_output_pin_half: assert property (p_clock_output_pin_half)
    else $error("clock output did not toggle on cpu tick");

  property p_xtal_free;
    @(posedge sys_clk) disable iff (!rst_b)
      crystalOutPinOe |-> (activeSrc_ff != SRC_XTAL) && !rtcUsesXtal &&
        !wdtUsesXtal;
  endproperty
  a_xtal_free: assert property (p_xtal_free)
    else $error("clock output driven while crystal in use");

  property p_oe_en;
    @(posedge sys_clk) disable iff (!rst_b)
      !tune_ff.clkOutEn |-> !crystalOutPinOe ##1 (!tune_ff.clkOutEn ||
        crystalOutPinOe || !clkOutAllowed);
  endproperty
  a_oe_en: assert property (p_oe_en)
    else $error("clock output driven with enable clear");

  property p_sw_begin;
    @(posedge sys_clk) disable iff (!rst_b)
      s_swBegin |=> !switchDone_ff && (swState_ff == ST_WAIT);
  endproperty
  a_sw_begin: assert property (p_sw_begin)
    else $error("done flag not cleared at switch start");

  property p_sw_end;
    @(posedge sys_clk) disable iff (!rst_b)
      s_swEnd |=> switchDone_ff && (activeSrc_ff == $past(pendSrc_ff));
  endproperty
  a_sw_end: assert property (p_sw_end)
    else $error("done flag not set at switch end");

  property p_refuse;
    @(posedge sys_clk) disable iff (!rst_b)
      cfgRefused |=> $stable(pendSrc_ff) && $stable(wdRateLow_ff);
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("configuration write accepted during switch");

  property p_src_ready;
    @(posedge sys_clk) disable iff (!rst_b)
      $changed(activeSrc_ff) |-> $past(srcRdy[pendSrc_ff]);
  endproperty
  a_src_ready: assert property (p_src_ready)
    else $error("source changed before new source ready");

  property p_trim_load;
    @(posedge sys_clk) disable iff (!rst_b)
      porEvt |=> (tune_ff.tune == TUNE_FACTORY) && !tune_ff.clkOutEn;
  endproperty
  a_trim_load: assert property (p_trim_load)
    else $error("trim not loaded with factory value");

  property p_wd_reset;
    @(posedge sys_clk) disable iff (!rst_b)
      (wdtRstEvt && !porEvt) |=> wdctl_ff.timeoutFlag && wdctl_ff.run &&
        (wdctl_ff.prescale == WD_PRESCALE_RST) && wdctl_ff.clkSel;
  endproperty
  a_wd_reset: assert property (p_wd_reset)
    else $error("watchdog control wrong after watchdog reset");

  property p_doubler;
    @(posedge sys_clk) disable iff (!rst_b)
      (activeSrc_ff == SRC_RC && doubler_ff && fallTick[SRC_RC])
        |-> cpuClockTick;
  endproperty
  a_doubler: assert property (p_doubler)
    else $error("doubler missed falling edge tick");

endmodule : ccoc_top

//--- dv/tb.sv
// self-checking bench for the clock source and output control block
// assumes ccoc_pkg and ccoc_top are compiled first; bench drives all pins
`timescale 1ns/100ps
module tb;
  import ccoc_pkg::*;
  typedef struct packed {
    logic [7:0] idx;
    logic [7:0] wd;
    logic [7:0] rd;
    logic [1:0] rs;
  } ccoc_row_s;
  localparam logic [5:0] TF = 6'h2A; // arbitrary factory trim
  logic sys_clk, rst_b, porEvt, wdtRstEvt, rtcUsesXtal, wdtUsesXtal;
  logic [3:0] oscLvlIn, oscRdyIn, wstrb;
  logic [11:0] awaddr, araddr;
  logic awvalid, wvalid, bready, arvalid, rready, po;
  logic awready, wready, bvalid, arready, rvalid, cpuClockTick;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, resp;
  logic wdOscRateLow, rcDoublerOn, rcSysSel, lowPowerAccess, irqOut;
  logic crystalOutPinO, crystalOutPinOe;
  logic [5:0] rcTune;
  ccoc_src_e activeSrc;
  ccoc_wdctl_s wdCtl;
  int errorCnt = 0, nTests = 0, cyc = 0, ticks, flips;
  // register cases plus one unmapped index (SLVERR): write, then read back
  ccoc_row_s rows [8] = '{
    '{IDX_TUNE, 8'h3A, 8'h3A, RESP_OKAY},
    '{IDX_TUNE, 8'h80, 8'h80, RESP_OKAY},
    '{IDX_WDCTL, 8'hFF, 8'hE5, RESP_OKAY},
    '{IDX_WDCTL, 8'h00, 8'h00, RESP_OKAY},
    '{IDX_AUX, 8'h80, 8'h80, RESP_OKAY},
    '{IDX_USER_CONFIG_TWO, 8'h80, 8'h80, RESP_OKAY},
    '{IDX_IRQCLR, 8'h00, 8'h00, RESP_OKAY},
    '{8'h40, 8'h5A, 8'h00, RESP_SLVERR}};

  ccoc_top #(.TUNE_FACTORY(TF)) dut_u (
    .sys_clk(sys_clk), .rst_b(rst_b), .porEvt(porEvt),
    .wdtRstEvt(wdtRstEvt), .oscLvlIn(oscLvlIn), .oscRdyIn(oscRdyIn),
    .rtcUsesXtal(rtcUsesXtal), .wdtUsesXtal(wdtUsesXtal),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .cpuClockTick(cpuClockTick),
    .activeSrc(activeSrc), .wdOscRateLow(wdOscRateLow),
    .rcDoublerOn(rcDoublerOn), .rcTune(rcTune), .rcSysSel(rcSysSel),
    .lowPowerAccess(lowPowerAccess), .wdCtl(wdCtl),
    .crystalOutPinO(crystalOutPinO), .crystalOutPinOe(crystalOutPinOe),
    .irqOut(irqOut));

  // 200 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // oscillator levels as free-running tick streams; hang guard
  always @(posedge sys_clk) begin
    oscLvlIn <= oscLvlIn + 4'h1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errorCnt++;
      wrap_up();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    nTests++;
    if (g !== e) begin
      errorCnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // write one register byte; waits for the response
  task automatic axw(input logic [7:0] idx, input logic [7:0] d);
    logic a, w, b;
    @(posedge sys_clk);
    awaddr <= {2'h0, idx, 2'h0};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge sys_clk);
      a = awvalid && awready;
      w = wvalid && wready;
      b = bvalid;
      resp = bresp;
      @(posedge sys_clk);
      if (a) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask : axw

  // read one register word into rd
  task automatic axr(input logic [7:0] idx);
    logic a, b;
    @(posedge sys_clk);
    araddr <= {2'h0, idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge sys_clk);
      a = arvalid && arready;
      b = rvalid;
      rd = rdata;
      resp = rresp;
      @(posedge sys_clk);
      if (a) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask : axr

  task automatic rc(input string nm, input logic [7:0] idx,
                    input logic [7:0] e);
    axr(idx);
    chk(nm, {24'h0, e}, rd);
  endtask : rc

  // one-cycle reset cause pulse, power-on when p is set
  task automatic pulse(input bit p);
    @(posedge sys_clk);
    porEvt <= p;
    wdtRstEvt <= !p;
    @(posedge sys_clk);
    porEvt <= 1'b0;
    wdtRstEvt <= 1'b0;
  endtask : pulse

  task automatic waitsrc(input ccoc_src_e s);
    int i;
    i = 0;
    @(negedge sys_clk);
    while (activeSrc !== s && i < 40) begin
      @(negedge sys_clk);
      i++;
    end
    chk("activeSrc", s, activeSrc);
  endtask : waitsrc

  task automatic wrap_up();
    if (errorCnt == 0 && nTests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up

  // ****************************************************
  // main sequence
  // ****************************************************
  initial begin
    {rst_b, porEvt, wdtRstEvt, rtcUsesXtal, wdtUsesXtal} = 5'h00;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    oscLvlIn = 4'h0;
    oscRdyIn = 4'hF;
    wstrb = 4'hF;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0;
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    pulse(1'b1);
    rc("tune", IDX_TUNE, {2'h0, TF});
    rc("wdctl", IDX_WDCTL, 8'hE5);
    rc("aux", IDX_AUX, 8'h00);
    rc("clkcfg", IDX_CLKCFG, 8'h81);
    for (int i = 0; i < 8; i++) begin
      axw(rows[i].idx, rows[i].wd);
      chk("bresp", {30'h0, rows[i].rs}, {30'h0, resp});
      axr(rows[i].idx);
      chk("rresp", {30'h0, rows[i].rs}, {30'h0, resp});
      chk("rdata", {24'h0, rows[i].rd}, rd);
    end
    @(negedge sys_clk);
    chk("lowPowerAccess", 1, lowPowerAccess);
    chk("rcDoublerOn", 1, rcDoublerOn);
    chk("rcSysSel", 1, rcSysSel);
    // doubled RC ticks on both edges: one tick every two cycles
    ticks = 0;
    repeat (16) begin
      @(negedge sys_clk);
      if (cpuClockTick === 1'b1) ticks++;
    end
    chk("dblTicks", 8, ticks);
    // a plain reset keeps the trim; cause pulses reload it
    axw(IDX_TUNE, 8'h55);
    @(posedge sys_clk);
    rst_b <= 1'b0;
    @(posedge sys_clk);
    rst_b <= 1'b1;
    rc("tune", IDX_TUNE, 8'h55);
    rc("aux", IDX_AUX, 8'h00);
    pulse(1'b0);
    rc("tune", IDX_TUNE, {2'h0, TF});
    rc("wdctl", IDX_WDCTL, 8'hE7);
    chk("wdCtl", 8'hE7, wdCtl);
    pulse(1'b1);
    rc("wdctl", IDX_WDCTL, 8'hE5);
    // clock output at half the cpu clock rate
    axw(IDX_TUNE, 8'h5B);
    @(negedge sys_clk);
    chk("rcTune", 6'h1B, rcTune);
    chk("oe", 1, crystalOutPinOe);
    ticks = 0;
    flips = 0;
    po = crystalOutPinO;
    repeat (64) begin
      @(negedge sys_clk);
      if (cpuClockTick === 1'b1) ticks++;
      if (crystalOutPinO !== po) flips++;
      po = crystalOutPinO;
    end
    flips = (ticks > 4 && flips >= ticks - 1 && flips <= ticks + 1);
    chk("halfrate", 1, flips);
    @(posedge sys_clk);
    rtcUsesXtal <= 1'b1;
    @(negedge sys_clk);
    chk("oe", 0, crystalOutPinOe);
    @(posedge sys_clk);
    rtcUsesXtal <= 1'b0;
    wdtUsesXtal <= 1'b1;
    @(negedge sys_clk);
    chk("oe", 0, crystalOutPinOe);
    @(posedge sys_clk);
    wdtUsesXtal <= 1'b0;
    axw(IDX_TUNE, 8'h1B);
    @(negedge sys_clk);
    chk("oe", 0, crystalOutPinOe);
    axw(IDX_TUNE, 8'h5B);
    // switch to crystal; a config write while busy is refused
    axw(IDX_IRQEN, 8'h03);
    @(posedge sys_clk);
    oscRdyIn <= 4'hB;
    axw(IDX_CLKCFG, 8'h02);
    axr(IDX_CLKCFG);
    chk("done", 0, rd[7]);
    chk("activeSrc", SRC_RC, activeSrc);
    axw(IDX_CLKCFG, 8'h03);
    rc("irqstat", IDX_IRQSTAT, 8'h02);
    @(negedge sys_clk);
    chk("irqOut", 1, irqOut);
    @(posedge sys_clk);
    oscRdyIn <= 4'hF;
    waitsrc(SRC_XTAL);
    chk("oe", 0, crystalOutPinOe);
    rc("clkcfg", IDX_CLKCFG, 8'h82);
    rc("irqstat", IDX_IRQSTAT, 8'h03);
    axw(IDX_IRQCLR, 8'h03);
    rc("irqstat", IDX_IRQSTAT, 8'h00);
    chk("irqOut", 0, irqOut);
    // masked completion, external input, then watchdog oscillator
    axw(IDX_IRQEN, 8'h00);
    axw(IDX_CLKCFG, 8'h07);
    waitsrc(SRC_EXT);
    chk("wdOscRateLow", 1, wdOscRateLow);
    chk("oe", 1, crystalOutPinOe);
    rc("irqstat", IDX_IRQSTAT, 8'h01);
    chk("irqOut", 0, irqOut);
    axw(IDX_CLKCFG, 8'h00);
    waitsrc(SRC_WDOSC);
    chk("wdOscRateLow", 0, wdOscRateLow);
    wrap_up();
  end
endmodule : tb
